// ### include/cis_defines.vh
// Purpose: constants for the interrupt sequencer
// Assumes: 20 MHz core clock, 16 vectors, 12-bit program counter
// Notes:   vector word address equals vector index
`ifndef CIS_DEFINES_VH
`define CIS_DEFINES_VH
`define CIS_NSRC          16
`define CIS_IDXW          4
`define CIS_PCW           12
`define CIS_SPW           16
`define CIS_GIE_BIT       7
`define CIS_FLAGS_RST     8'h00
`define CIS_SP_RST        16'h0000
`define CIS_CLK_NS        50
`define CIS_ENTRY_NS      200
`define CIS_ENTRY_CYC     ((`CIS_ENTRY_NS + `CIS_CLK_NS - 1) / `CIS_CLK_NS)
`define CIS_JUMP_NS       150
`define CIS_JUMP_CYC      ((`CIS_JUMP_NS + `CIS_CLK_NS - 1) / `CIS_CLK_NS)
`define CIS_WAKE_NS       200
`define CIS_WAKE_CYC      ((`CIS_WAKE_NS + `CIS_CLK_NS - 1) / `CIS_CLK_NS)
`define CIS_RETURN_FROM_IRQ_INSTRUCTION_NS       200
`define CIS_RETURN_FROM_IRQ_INSTRUCTION_CYC      ((`CIS_RETURN_FROM_IRQ_INSTRUCTION_NS + `CIS_CLK_NS - 1) / `CIS_CLK_NS)
`define CIS_ST_RUN        3'h0
`define CIS_ST_WAKE       3'h1
`define CIS_ST_ENTRY      3'h2
`define CIS_ST_JUMP       3'h3
`define CIS_ST_RETURN_FROM_IRQ_INSTRUCTION       3'h4
`define CIS_ST_RESET      3'h5
`endif

// ### core/cis_prio_enc.v
// Purpose: fixed priority pick, lowest index wins
// Assumes: index 0 is highest priority
// Notes:   combinational
`timescale 1ns/1ns
module cis_prio_enc #(
    parameter N = 16,
    parameter W = 4
) (
    // request vector
    input  wire [N-1:0] i_req,
    // result
    output reg          o_any,
    output reg  [W-1:0] o_idx
);
    integer k;
    always @* begin
        o_any = 1'b0;
        o_idx = {W{1'b0}};
        for (k = N - 1; k >= 0; k = k - 1) begin
            if (i_req[k]) begin
                o_any = 1'b1;
                o_idx = k[W-1:0];
            end
        end
    end
endmodule

// ### core/cis_sequencer.v
// Purpose: reset and interrupt sequencing for an 8-bit core
// Assumes: core pulses instruction boundaries; core clock undivided
// Notes:   vector 0 is reset; sources 1..15 map to vectors 1..15
// Contract
// - core clock used directly, no division
// - reset and sources own lowest vectors
// - take only when enabled and global on
// - lowest vector wins; reset first
// - accepting interrupt clears global enable
// - global set in handler allows nesting
// - return instruction sets global enable
// - hardware clears flag on vectoring
// - writing one clears flag; zero keeps
// - disabled flag held until enabled or cleared
// - flags held while global off, served later
// - level source requests only while present
// - one main instruction after return
// - flags register not saved or restored
// - global disable acts at once
// - instruction after global enable runs first
// - entry takes four cycles, pushes counter
// - vector jump takes three cycles
// - multi-cycle instruction completes before entry
// - sleep wake adds four cycles
// - return four cycles, pop, sp plus two
// - global enable is flags bit 7
// - push decrements stack pointer by two
`timescale 1ns/1ns
`include "cis_defines.vh"
module cis_sequencer (
    // clock and reset
    input  wire                  i_clock,
    input  wire                  i_rstn,
    // peripheral sources
    input  wire [`CIS_NSRC-1:0]  i_flag_set,
    input  wire [`CIS_NSRC-1:0]  i_level_req,
    input  wire [`CIS_NSRC-1:0]  i_is_level,
    input  wire [`CIS_NSRC-1:0]  i_src_en,
    input  wire [`CIS_NSRC-1:0]  i_flag_wr_clr,
    // core pipeline
    input  wire                  i_insn_done,
    input  wire                  i_insn_multi,
    input  wire                  i_sleeping,
    input  wire                  i_exec_sei,
    input  wire                  i_exec_cli,
    input  wire                  i_exec_return_from_irq_instruction,
    input  wire                  i_flags_wr,
    input  wire [7:0]            i_flags_wdata,
    input  wire [7:0]            i_alu_flags,
    input  wire                  i_alu_flags_we,
    input  wire [`CIS_PCW-1:0]   i_pc,
    input  wire [`CIS_PCW-1:0]   i_jump_target,
    input  wire                  i_sp_wr,
    input  wire [`CIS_SPW-1:0]   i_sp_wdata,
    input  wire [7:0]            i_stack_rdata,
    // outputs to core and stack
    output wire                  o_core_stall,
    output reg  [7:0]            o_flags,
    output reg  [`CIS_SPW-1:0]   o_sp,
    output reg                   o_pc_load,
    output reg  [`CIS_PCW-1:0]   o_pc_value,
    output reg                   o_stack_we,
    output reg                   o_stack_re,
    output reg  [`CIS_SPW-1:0]   o_stack_addr,
    output reg  [7:0]            o_stack_wdata,
    output reg  [`CIS_NSRC-1:0]  o_flag_pending,
    output reg                   o_irq_ack,
    output reg  [`CIS_IDXW-1:0]  o_irq_idx
);
    // all registers on i_clock, no divider
    // counter start points, cut to the counter width
    localparam integer ENTRY_M1  = `CIS_ENTRY_CYC - 1;
    localparam integer ENTRY_M2  = `CIS_ENTRY_CYC - 2;
    localparam integer JUMP_M1   = `CIS_JUMP_CYC - 1;
    localparam integer WAKE_M1   = `CIS_WAKE_CYC - 1;
    localparam integer RETURN_FROM_IRQ_INSTRUCTION_M1   = `CIS_RETURN_FROM_IRQ_INSTRUCTION_CYC - 1;
    localparam integer RETURN_FROM_IRQ_INSTRUCTION_M2   = `CIS_RETURN_FROM_IRQ_INSTRUCTION_CYC - 2;
    localparam integer RETURN_FROM_IRQ_INSTRUCTION_M3   = `CIS_RETURN_FROM_IRQ_INSTRUCTION_CYC - 3;
    localparam [3:0]   ENTRY_TOP = ENTRY_M1[3:0];
    localparam [3:0]   ENTRY_NXT = ENTRY_M2[3:0];
    localparam [3:0]   JUMP_TOP  = JUMP_M1[3:0];
    localparam [3:0]   WAKE_TOP  = WAKE_M1[3:0];
    localparam [3:0]   RETURN_FROM_IRQ_INSTRUCTION_TOP  = RETURN_FROM_IRQ_INSTRUCTION_M1[3:0];
    localparam [3:0]   RETURN_FROM_IRQ_INSTRUCTION_NXT  = RETURN_FROM_IRQ_INSTRUCTION_M2[3:0];
    localparam [3:0]   RETURN_FROM_IRQ_INSTRUCTION_3RD  = RETURN_FROM_IRQ_INSTRUCTION_M3[3:0];

    reg [2:0]              state_r;
    reg [2:0]              state_nxt;
    reg [3:0]              cnt_r;
    reg [3:0]              cnt_nxt;
    reg [`CIS_IDXW-1:0]    win_r;
    reg [`CIS_PCW-1:0]     ret_pc_r;
    reg                    hold_one_r;
    reg                    reset_seq_r;
    reg [`CIS_NSRC-1:0]    flag_r;
    reg [`CIS_NSRC-1:0]    flag_nxt;
    reg [`CIS_PCW-9:0]     pop_hi_r;
    reg [7:0]              flags_nxt;

    wire [`CIS_NSRC-1:0]   raw_req;
    wire [`CIS_NSRC-1:0]   elig;
    wire                   any_req;
    wire [`CIS_IDXW-1:0]   pick;
    wire                   gie;
    wire                   take;
    reg                    entry_start;

    // level sources bypass flags; flag sources use stored flag
    assign raw_req = (i_is_level & i_level_req) | (~i_is_level & flag_r);
    assign elig    = raw_req & i_src_en;
    assign gie     = o_flags[`CIS_GIE_BIT] & ~i_exec_cli;

    cis_prio_enc #(
        .N (`CIS_NSRC),
        .W (`CIS_IDXW)
    ) u_prio (
        .i_req (elig),
        .o_any (any_req),
        .o_idx (pick)
    );

    // arbitrate only at completed instruction boundaries
    assign take = (state_r == `CIS_ST_RUN) & i_insn_done & any_req & gie
                  & ~hold_one_r & ~i_exec_sei & ~i_exec_return_from_irq_instruction;

    assign o_core_stall = (state_r != `CIS_ST_RUN);

    // flags: set wins over clear
    always @* begin
        flag_nxt = flag_r & ~i_flag_wr_clr;
        if (entry_start && !i_is_level[pick]) begin
            flag_nxt[pick] = 1'b0;
        end
        flag_nxt = flag_nxt | (i_flag_set & ~i_is_level);
    end

    always @* begin
        entry_start = 1'b0;
        if (take) begin
            entry_start = 1'b1;
        end
    end

    // processor flags: only the global bit is touched by sequencing
    always @* begin
        flags_nxt = o_flags;
        if (i_alu_flags_we) begin
            flags_nxt[6:0] = i_alu_flags[6:0];
        end
        if (i_flags_wr) begin
            flags_nxt = i_flags_wdata;
        end
        if (i_exec_sei) begin
            flags_nxt[`CIS_GIE_BIT] = 1'b1;
        end
        if (i_exec_cli) begin
            flags_nxt[`CIS_GIE_BIT] = 1'b0;
        end
        if (entry_start) begin
            flags_nxt[`CIS_GIE_BIT] = 1'b0;
        end
        if (state_r == `CIS_ST_RETURN_FROM_IRQ_INSTRUCTION && cnt_r == 4'h0) begin
            flags_nxt[`CIS_GIE_BIT] = 1'b1;
        end
    end

    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            `CIS_ST_RESET: begin
                state_nxt = `CIS_ST_JUMP;
                cnt_nxt   = JUMP_TOP;
            end
            `CIS_ST_RUN: begin
                if (take && i_sleeping) begin
                    state_nxt = `CIS_ST_WAKE;
                    cnt_nxt   = WAKE_TOP;
                end else if (take) begin
                    state_nxt = `CIS_ST_ENTRY;
                    cnt_nxt   = ENTRY_TOP;
                end else if (i_exec_return_from_irq_instruction) begin
                    state_nxt = `CIS_ST_RETURN_FROM_IRQ_INSTRUCTION;
                    cnt_nxt   = RETURN_FROM_IRQ_INSTRUCTION_TOP;
                end
            end
            `CIS_ST_WAKE: begin
                if (cnt_r == 4'h0) begin
                    state_nxt = `CIS_ST_ENTRY;
                    cnt_nxt   = ENTRY_TOP;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            `CIS_ST_ENTRY: begin
                if (cnt_r == 4'h0) begin
                    state_nxt = `CIS_ST_JUMP;
                    cnt_nxt   = JUMP_TOP;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            `CIS_ST_JUMP, `CIS_ST_RETURN_FROM_IRQ_INSTRUCTION: begin
                if (cnt_r == 4'h0) begin
                    state_nxt = `CIS_ST_RUN;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default: begin
                state_nxt = `CIS_ST_RUN;
                cnt_nxt   = 4'h0;
            end
        endcase
    end

    always @(posedge i_clock) begin
        if (!i_rstn) begin
            state_r        <= `CIS_ST_RESET;
            cnt_r          <= 4'h0;
            win_r          <= {`CIS_IDXW{1'b0}};
            ret_pc_r       <= {`CIS_PCW{1'b0}};
            pop_hi_r       <= {(`CIS_PCW-8){1'b0}};
            hold_one_r     <= 1'b0;
            reset_seq_r    <= 1'b1;
            flag_r         <= {`CIS_NSRC{1'b0}};
            o_flags        <= `CIS_FLAGS_RST;
            o_sp           <= `CIS_SP_RST;
            o_pc_load      <= 1'b0;
            o_pc_value     <= {`CIS_PCW{1'b0}};
            o_stack_we     <= 1'b0;
            o_stack_re     <= 1'b0;
            o_stack_addr   <= `CIS_SP_RST;
            o_stack_wdata  <= 8'h00;
            o_flag_pending <= {`CIS_NSRC{1'b0}};
            o_irq_ack      <= 1'b0;
            o_irq_idx      <= {`CIS_IDXW{1'b0}};
        end else begin
            state_r        <= state_nxt;
            cnt_r          <= cnt_nxt;
            flag_r         <= flag_nxt;
            o_flag_pending <= flag_nxt;
            o_flags        <= flags_nxt;
            o_pc_load      <= 1'b0;
            o_stack_we     <= 1'b0;
            o_stack_re     <= 1'b0;
            o_irq_ack      <= entry_start;
            if (entry_start) begin
                win_r     <= pick;
                o_irq_idx <= pick;
                ret_pc_r  <= i_pc;
            end
            // one main instruction after return before next entry
            if (state_r == `CIS_ST_RETURN_FROM_IRQ_INSTRUCTION && cnt_r == 4'h0) begin
                hold_one_r <= 1'b1;
            end else if (state_r == `CIS_ST_RUN && i_insn_done) begin
                hold_one_r <= 1'b0;
            end
            if (i_sp_wr) begin
                o_sp <= i_sp_wdata;
            end
            case (state_r)
                `CIS_ST_ENTRY: begin
                    // push low then high byte, sp down by two
                    if (cnt_r == ENTRY_TOP) begin
                        o_stack_we    <= 1'b1;
                        o_stack_addr  <= o_sp;
                        o_stack_wdata <= ret_pc_r[7:0];
                    end else if (cnt_r == ENTRY_NXT) begin
                        o_stack_we    <= 1'b1;
                        o_stack_addr  <= o_sp - 16'h0001;
                        o_stack_wdata <= {4'h0, ret_pc_r[`CIS_PCW-1:8]};
                        o_sp          <= o_sp - 16'h0002;
                    end
                    if (cnt_r == 4'h0) begin
                        o_pc_load  <= 1'b1;
                        o_pc_value <= {{(`CIS_PCW-`CIS_IDXW){1'b0}}, win_r};
                    end
                end
                `CIS_ST_JUMP: begin
                    if (reset_seq_r && cnt_r == JUMP_TOP) begin
                        o_pc_load  <= 1'b1;
                        o_pc_value <= {`CIS_PCW{1'b0}};
                    end
                    if (cnt_r == 4'h0) begin
                        o_pc_load   <= 1'b1;
                        o_pc_value  <= i_jump_target;
                        reset_seq_r <= 1'b0;
                    end
                end
                `CIS_ST_RETURN_FROM_IRQ_INSTRUCTION: begin
                    // pop high then low byte, sp up by two
                    // read data lags its strobe by one cycle
                    if (cnt_r == RETURN_FROM_IRQ_INSTRUCTION_TOP) begin
                        o_stack_re   <= 1'b1;
                        o_stack_addr <= o_sp + 16'h0001;
                    end else if (cnt_r == RETURN_FROM_IRQ_INSTRUCTION_NXT) begin
                        o_stack_re   <= 1'b1;
                        o_stack_addr <= o_sp + 16'h0002;
                    end else if (cnt_r == RETURN_FROM_IRQ_INSTRUCTION_3RD) begin
                        pop_hi_r <= i_stack_rdata[`CIS_PCW-9:0];
                        o_sp     <= o_sp + 16'h0002;
                    end
                    if (cnt_r == 4'h0) begin
                        o_pc_load  <= 1'b1;
                        o_pc_value <= {pop_hi_r, i_stack_rdata};
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule

// ### tb/cis_checker.sv
// Purpose: port assertions for the interrupt sequencer
// Assumes: one clock, sync active-low reset
// Notes:   bound into every cis_sequencer
`timescale 1ns/1ns
module cis_checker (
    // clock and reset
    input wire        i_clock,
    input wire        i_rstn,
    // watched inputs
    input wire        i_insn_done,
    input wire        i_sleeping,
    input wire        i_exec_sei,
    input wire        i_exec_cli,
    input wire        i_exec_return_from_irq_instruction,
    input wire [15:0] i_flag_set,
    input wire [15:0] i_flag_wr_clr,
    input wire [11:0] i_jump_target,
    // watched outputs
    input wire        o_core_stall,
    input wire [7:0]  o_flags,
    input wire [15:0] o_sp,
    input wire        o_pc_load,
    input wire [11:0] o_pc_value,
    input wire [15:0] o_flag_pending,
    input wire        o_irq_ack,
    input wire [3:0]  o_irq_idx
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    gie_clear_a: assert property (o_irq_ack |-> !o_flags[7])
        else $error("global enable kept on entry");
    take_gate_a: assert property (o_irq_ack |-> $past(o_flags[7]) && $past(i_insn_done))
        else $error("take without enable or boundary");
    cli_block_a: assert property (i_exec_cli && i_insn_done |=> !o_irq_ack)
        else $error("take beside disable");
    sei_delay_a: assert property (i_exec_sei |=> !o_irq_ack)
        else $error("take right after enable");
    sp_push_a: assert property (o_irq_ack && !$past(i_sleeping) |-> ##2
        (o_sp == $past(o_sp) - 16'h0002))
        else $error("push not minus two");
    entry_len_a: assert property (o_irq_ack && !$past(i_sleeping) |-> !o_pc_load [*4]
        ##1 (o_pc_load && o_pc_value == {8'h00, o_irq_idx}))
        else $error("entry length or vector wrong");
    jump_len_a: assert property (o_irq_ack && !$past(i_sleeping) |-> ##7 (o_pc_load
        && o_pc_value == i_jump_target && !o_core_stall))
        else $error("jump length wrong");
    wake_len_a: assert property (o_irq_ack && $past(i_sleeping) |-> !o_pc_load [*8]
        ##1 o_pc_load)
        else $error("wake entry length wrong");
    return_from_irq_instruction_gie_a: assert property (i_exec_return_from_irq_instruction && !o_core_stall |-> ##[1:5] o_flags[7])
        else $error("return left enable off");
    one_insn_a: assert property (i_exec_return_from_irq_instruction && !o_core_stall |-> ##6 !o_irq_ack)
        else $error("take right after return");
    wr_clear_a: assert property (1 |=> (o_flag_pending & $past(i_flag_wr_clr)
        & ~$past(i_flag_set)) == 16'h0000)
        else $error("write one did not clear");
    cover property (o_irq_ack && !$past(i_sleeping));
    cover property (o_irq_ack && $past(i_sleeping));
    cover property (i_exec_return_from_irq_instruction && !o_core_stall);
endmodule
bind cis_sequencer cis_checker u_chk (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_insn_done(i_insn_done), .i_sleeping(i_sleeping),
    .i_exec_sei(i_exec_sei), .i_exec_cli(i_exec_cli), .i_exec_return_from_irq_instruction(i_exec_return_from_irq_instruction),
    .i_flag_set(i_flag_set), .i_flag_wr_clr(i_flag_wr_clr), .i_jump_target(i_jump_target),
    .o_core_stall(o_core_stall), .o_flags(o_flags), .o_sp(o_sp), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_flag_pending(o_flag_pending), .o_irq_ack(o_irq_ack),
    .o_irq_idx(o_irq_idx)
);

// ### tb/cis_core_model.sv
// Purpose: core pipeline and stack memory model
// Assumes: stack lives in low 256 bytes
// Notes:   read data is scrambled when not read
`timescale 1ns/1ns
module cis_core_model (
    // clock and reset
    input  wire        i_clock,
    input  wire        i_rstn,
    // bench control
    input  wire        i_hold,
    // from sequencer
    input  wire        i_core_stall,
    input  wire        i_pc_load,
    input  wire [11:0] i_pc_value,
    input  wire        i_stack_we,
    input  wire        i_stack_re,
    input  wire [15:0] i_stack_addr,
    input  wire [7:0]  i_stack_wdata,
    // to sequencer
    output wire        o_insn_done,
    output wire [11:0] o_pc,
    output reg  [7:0]  o_stack_rdata
);
    reg [7:0]  mem_r [0:255];
    reg [11:0] pc_r;
    // shows the next instruction, the return address on a take
    assign o_pc = pc_r + {11'h000, o_insn_done};
    // hold stretches a multi-cycle instruction
    assign o_insn_done = !i_core_stall && !i_hold;
    // flags never touched here, software keeps them
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            pc_r <= 12'h000;
            o_stack_rdata <= 8'h00;
        end else begin
            if (i_pc_load)
                pc_r <= i_pc_value;
            else if (o_insn_done)
                pc_r <= pc_r + 12'h001;
            if (i_stack_we)
                mem_r[i_stack_addr[7:0]] <= i_stack_wdata;
            o_stack_rdata <= i_stack_re ? mem_r[i_stack_addr[7:0]] : ~o_stack_rdata;
        end
    end
endmodule

// ### tb/tb_top.sv
// Purpose: self-checking bench for cis_sequencer
// Assumes: inputs driven 5 ns after the rising edge
// Notes:   row loop first, awkward cases after
`timescale 1ns/1ns
module tb_top;
    reg         i_clock, i_rstn, i_sleeping, i_exec_sei, i_exec_cli, i_exec_return_from_irq_instruction, hold;
    reg         i_flags_wr, i_alu_flags_we, i_sp_wr;
    reg  [15:0] i_flag_set, i_level_req, i_is_level, i_src_en, i_flag_wr_clr, i_sp_wdata;
    reg  [7:0]  i_flags_wdata, i_alu_flags;
    reg  [11:0] i_jump_target, ret_pc;
    wire        i_insn_done, o_core_stall, o_pc_load, o_stack_we, o_stack_re, o_irq_ack;
    wire [11:0] i_pc, o_pc_value;
    wire [7:0]  i_stack_rdata, o_flags, o_stack_wdata;
    wire [15:0] o_sp, o_stack_addr, o_flag_pending;
    wire [3:0]  o_irq_idx;
    wire        i_insn_multi = 1'b0;
    reg  [51:0] rows [0:4];
    integer     failures, check_count, ack_cnt, cyc, r, base;
    cis_sequencer u_dut (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_flag_set(i_flag_set),
        .i_level_req(i_level_req), .i_is_level(i_is_level), .i_src_en(i_src_en),
        .i_flag_wr_clr(i_flag_wr_clr), .i_insn_done(i_insn_done), .i_insn_multi(i_insn_multi),
        .i_sleeping(i_sleeping), .i_exec_sei(i_exec_sei), .i_exec_cli(i_exec_cli),
        .i_exec_return_from_irq_instruction(i_exec_return_from_irq_instruction), .i_flags_wr(i_flags_wr), .i_flags_wdata(i_flags_wdata),
        .i_alu_flags(i_alu_flags), .i_alu_flags_we(i_alu_flags_we), .i_pc(i_pc),
        .i_jump_target(i_jump_target), .i_sp_wr(i_sp_wr), .i_sp_wdata(i_sp_wdata),
        .i_stack_rdata(i_stack_rdata), .o_core_stall(o_core_stall), .o_flags(o_flags),
        .o_sp(o_sp), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_stack_we(o_stack_we),
        .o_stack_re(o_stack_re), .o_stack_addr(o_stack_addr), .o_stack_wdata(o_stack_wdata),
        .o_flag_pending(o_flag_pending), .o_irq_ack(o_irq_ack), .o_irq_idx(o_irq_idx)
    );
    cis_core_model u_core (.i_clock(i_clock), .i_rstn(i_rstn), .i_hold(hold),
        .i_core_stall(o_core_stall), .i_pc_load(o_pc_load), .i_pc_value(o_pc_value),
        .i_stack_we(o_stack_we), .i_stack_re(o_stack_re), .i_stack_addr(o_stack_addr),
        .i_stack_wdata(o_stack_wdata), .o_insn_done(i_insn_done), .o_pc(i_pc),
        .o_stack_rdata(i_stack_rdata));
    always #25 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cyc = cyc + 1;
        if (o_irq_ack === 1'b1)
            ack_cnt = ack_cnt + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    task end_of_test;
        begin
            $display("checks %0d failures %0d", check_count, failures);
            if (failures == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input [8*8-1:0] name, input [15:0] exp, input [15:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("BAD %0s exp %h got %h", name, exp, got);
            end
        end
    endtask
    task step(input integer n);
        begin
            repeat (n) @(posedge i_clock);
            #5;
        end
    endtask
    task wait_sig(input integer want_ack);
        integer n;
        begin
            n = 0;
            while ((want_ack ? o_irq_ack !== 1'b1 : o_core_stall !== 1'b0) && n < 40) begin
                step(1);
                n = n + 1;
            end
            if (want_ack)
                chk("ack", 16'h0001, {15'h0000, o_irq_ack});
        end
    endtask
    task do_return_from_irq_instruction;
        begin
            wait_sig(0);
            i_exec_return_from_irq_instruction = 1'b1;
            step(1);
            i_exec_return_from_irq_instruction = 1'b0;
            step(1);
            wait_sig(0);
        end
    endtask
    initial begin
        {i_clock, i_rstn, i_sleeping, i_exec_sei, i_exec_cli, i_exec_return_from_irq_instruction, hold} = 7'h00;
        {i_flags_wr, i_alu_flags_we, i_sp_wr, i_flags_wdata, i_alu_flags} = 19'h00000;
        {i_flag_set, i_level_req, i_is_level, i_flag_wr_clr} = 64'h0;
        i_src_en = 16'hFFFF;
        i_sp_wdata = 16'h0100;
        i_jump_target = 12'h345;
        {failures, check_count, ack_cnt, cyc} = 128'h0;
        rows[0] = {16'h0002, 16'hFFFF, 4'h1, 16'h0000};
        rows[1] = {16'h8000, 16'hFFFF, 4'hF, 16'h0000};
        rows[2] = {16'h0C00, 16'hFFFF, 4'hA, 16'h0800};
        rows[3] = {16'h0C00, 16'h0800, 4'hB, 16'h0400};
        rows[4] = {16'h0060, 16'hFFFF, 4'h5, 16'h0040};
        step(10);
        chk("rflags", 16'h0000, {8'h00, o_flags});
        chk("rsp", 16'h0000, o_sp);
        i_rstn = 1'b1;
        wait_sig(0);
        {i_sp_wr, i_flags_wr, i_flags_wdata} = 10'h380;
        step(1);
        {i_sp_wr, i_flags_wr} = 2'b00;
        for (r = 0; r < 5; r = r + 1) begin
            i_src_en = rows[r][35:20];
            i_flag_set = rows[r][51:36];
            step(1);
            i_flag_set = 16'h0000;
            wait_sig(1);
            ret_pc = i_pc;
            chk("idx", {12'h000, rows[r][19:16]}, {12'h000, o_irq_idx});
            chk("pend", rows[r][15:0], o_flag_pending);
            step(2);
            chk("sp", 16'h00FE, o_sp);
            i_flag_wr_clr = 16'hFFFF;
            step(1);
            i_flag_wr_clr = 16'h0000;
            chk("clr", 16'h0000, o_flag_pending);
            do_return_from_irq_instruction;
            chk("spret", 16'h0100, o_sp);
            chk("retpc", {4'h1, ret_pc}, {3'h0, o_pc_load, o_pc_value});
        end
        i_src_en = 16'hFFFF;
        {i_exec_cli, i_flag_set} = 17'h10010;
        step(1);
        {i_exec_cli, i_flag_set} = 17'h00000;
        base = ack_cnt;
        step(10);
        chk("noack", base[15:0], ack_cnt[15:0]);
        chk("held", 16'h0010, o_flag_pending);
        {i_flags_wr, i_flags_wdata} = 9'h105;
        step(1);
        {i_flags_wr, i_sleeping, i_exec_sei} = 3'b011;
        step(1);
        i_exec_sei = 1'b0;
        wait_sig(1);
        i_sleeping = 1'b0;
        chk("wake", 16'h0004, {12'h000, o_irq_idx});
        chk("eflags", 16'h0005, {8'h00, o_flags});
        wait_sig(0);
        {i_alu_flags_we, i_alu_flags} = 9'h103;
        step(1);
        {i_alu_flags_we, i_flags_wr, i_flags_wdata} = 10'h183;
        step(1);
        {i_flags_wr, i_flag_set} = 17'h00002;
        step(1);
        i_flag_set = 16'h0000;
        wait_sig(1);
        chk("nest", 16'h0001, {12'h000, o_irq_idx});
        do_return_from_irq_instruction;
        do_return_from_irq_instruction;
        chk("rflags", 16'h0083, {8'h00, o_flags});
        chk("spret", 16'h0100, o_sp);
        {i_is_level, i_level_req, i_src_en} = {16'h0008, 16'h0008, 16'h0000};
        step(3);
        i_level_req = 16'h0000;
        i_src_en = 16'h0008;
        base = ack_cnt;
        step(10);
        chk("lvgone", base[15:0], ack_cnt[15:0]);
        {hold, i_level_req} = 17'h10008;
        step(5);
        chk("multi", base[15:0], ack_cnt[15:0]);
        hold = 1'b0;
        wait_sig(1);
        chk("level", 16'h0003, {12'h000, o_irq_idx});
        i_level_req = 16'h0000;
        do_return_from_irq_instruction;
        end_of_test;
    end
endmodule
